//--- ccrb_register_bank.sv
`timescale 1ns/1ps
`include "ccrb_regs.svh"
module ccrb_register_bank
   import ccrb_pkg::*;
#(
   parameter logic [37:0] WD_BASE_CYCLES = 38'(`CCRB_WD_BASE_CYCLES)
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access from serial front end
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   // commands and inputs from the rest of the charger
   input wire logic regResetCmd,
   input wire logic [1:0] watchdogPeriod,
   input wire logic [4:0] optimizedInputLimitIn,
   // watchdog
   output logic watchdogExpired,
   output logic watchdogKickSeen,
   // configuration fields
   output logic lowfreqPulseDisable,
   output logic [1:0] topoffDuration,
   output logic [3:0] minSystemVoltage,
   output logic [1:0] hotThresholdSel,
   output logic coldThresholdSel,
   output logic [1:0] warmVoltageSel,
   output logic warmCurrentSel,
   output logic [1:0] coolCurrentSel,
   output logic [3:0] sourceCurrentLimit,
   output logic [3:0] sourceVoltageLevel,
   output logic [4:0] optimizedInputLimit,
   // decoded values
   output logic [7:0] topoffMinutes,
   output logic [12:0] minSystemMv,
   output logic [11:0] sourceCurrentMa,
   output logic [12:0] sourceVoltageMv,
   output logic [11:0] optimizedInputMa,
   output logic hotProtectEnable
);

   ccrb_state_t cur;
   ccrb_state_t next_cur;

   // period code to cycle limit; 00 yields zero and disables
   function automatic logic [37:0] wdLimit(input ccrb_wd_period_t p);
      unique case (p)
         CCRB_WD_OFF: wdLimit = 38'h0;
         CCRB_WD_40S: wdLimit = WD_BASE_CYCLES;
         CCRB_WD_80S: wdLimit = WD_BASE_CYCLES << 1;
         CCRB_WD_160S: wdLimit = WD_BASE_CYCLES << 2;
      endcase
   endfunction

   // base plus 100 per count, in mA or mV
   function automatic logic [12:0] stepScale(input logic [12:0] base, input logic [4:0] code);
      stepScale = base + 13'(code) * 13'(`CCRB_STEP_100);
   endfunction

   logic wr07;
   logic wr08;
   logic wr09;
   logic kickWrite;
   logic [37:0] limit;
   logic periodChanged;
   logic [3:0] srcVClamped;

   assign wr07 = regWrite && regAddr == `CCRB_ADDR_TIMER_SYS;
   assign wr08 = regWrite && regAddr == `CCRB_ADDR_TEMP_PROFILE;
   assign wr09 = regWrite && regAddr == `CCRB_ADDR_SOURCE_LIMITS;
   assign kickWrite = wr07 && regWrData[`CCRB_BIT_WD_KICK];
   assign limit = wdLimit(ccrb_wd_period_t'(watchdogPeriod));
   assign periodChanged = watchdogPeriod != cur.wdPeriodSeen;

   always_comb
   begin
      next_cur = cur;
      next_cur.wdExpired = 1'b0;
      // kick lasts one cycle, then clears itself
      next_cur.watchdogKick = 1'b0;
      // status sampled every cycle; no reset command reaches it
      next_cur.optimizedInputLimit = optimizedInputLimitIn;
      next_cur.wdPeriodSeen = ccrb_wd_period_t'(watchdogPeriod);

      // host writes; 0Ah and unknown addresses drop the data
      if (wr07)
      begin
         next_cur.lowfreqPulseDisable = regWrData[`CCRB_BIT_LOWFREQ_DIS];
         next_cur.watchdogKick = regWrData[`CCRB_BIT_WD_KICK];
         next_cur.topoffDuration = regWrData[`CCRB_POS_TOPOFF +: 2];
         next_cur.minSystemVoltage = regWrData[`CCRB_POS_MINSYS +: 4];
      end
      if (wr08)
         next_cur.tempProfile = regWrData;
      if (wr09)
         next_cur.sourceLimits = regWrData;

      // watchdog: kick, reset command or period change restart it
      if (kickWrite || regResetCmd || periodChanged || limit == 38'h0)
         next_cur.wdCount = 38'h0;
      else if (cur.wdCount >= limit - 38'h1)
      begin
         next_cur.wdCount = 38'h0;
         next_cur.wdExpired = 1'b1;
      end
      else
         next_cur.wdCount = cur.wdCount + 38'h1;

      // expiry restores only the watchdog-resettable fields
      if (cur.wdExpired)
      begin
         next_cur.watchdogKick = 1'b0;
         next_cur.topoffDuration = `CCRB_RST_TOPOFF;
         next_cur.tempProfile = `CCRB_RST_TEMP_PROFILE;
         next_cur.sourceLimits = `CCRB_RST_SOURCE_LIMITS;
      end

      // register reset wins over any write in the same cycle
      if (regResetCmd)
      begin
         next_cur.lowfreqPulseDisable = `CCRB_RST_LOWFREQ_DIS;
         next_cur.watchdogKick = 1'b0;
         next_cur.topoffDuration = `CCRB_RST_TOPOFF;
         next_cur.minSystemVoltage = `CCRB_RST_MINSYS;
         next_cur.tempProfile = `CCRB_RST_TEMP_PROFILE;
         next_cur.sourceLimits = `CCRB_RST_SOURCE_LIMITS;
      end

      // read data registered; unmapped reads return zero
      if (regRead)
      begin
         unique case (regAddr)
            `CCRB_ADDR_TIMER_SYS: next_cur.rdData = {cur.lowfreqPulseDisable, cur.watchdogKick,
                                                     cur.topoffDuration, cur.minSystemVoltage};
            `CCRB_ADDR_TEMP_PROFILE: next_cur.rdData = cur.tempProfile;
            `CCRB_ADDR_SOURCE_LIMITS: next_cur.rdData = cur.sourceLimits;
            `CCRB_ADDR_OPT_INPUT: next_cur.rdData = {3'h0, cur.optimizedInputLimit};
            default: next_cur.rdData = 8'h00;
         endcase
      end
   end

   // status field has no documented reset; zero keeps sim clean
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cur <= '0;
         cur.minSystemVoltage <= `CCRB_RST_MINSYS;
         cur.tempProfile <= `CCRB_RST_TEMP_PROFILE;
         cur.sourceLimits <= `CCRB_RST_SOURCE_LIMITS;
         cur.wdPeriodSeen <= CCRB_WD_40S;
      end
      else
         cur <= next_cur;
   end

   assign regRdData = cur.rdData;
   assign watchdogExpired = cur.wdExpired;
   assign watchdogKickSeen = cur.watchdogKick;

   assign lowfreqPulseDisable = cur.lowfreqPulseDisable;
   assign topoffDuration = cur.topoffDuration;
   assign minSystemVoltage = cur.minSystemVoltage;
   assign hotThresholdSel = cur.tempProfile[`CCRB_POS_HOT +: 2];
   assign coldThresholdSel = cur.tempProfile[`CCRB_BIT_COLD];
   assign warmVoltageSel = cur.tempProfile[`CCRB_POS_WARM_V +: 2];
   assign warmCurrentSel = cur.tempProfile[`CCRB_BIT_WARM_I];
   assign coolCurrentSel = cur.tempProfile[`CCRB_POS_COOL_I +: 2];
   assign sourceCurrentLimit = cur.sourceLimits[`CCRB_POS_SRC_I +: 4];
   assign sourceVoltageLevel = cur.sourceLimits[`CCRB_POS_SRC_V +: 4];
   assign optimizedInputLimit = cur.optimizedInputLimit;

   // code 11 turns off source-mode thermal protection
   assign hotProtectEnable = hotThresholdSel != 2'h3;
   assign topoffMinutes = 8'(topoffDuration) * `CCRB_TOPOFF_STEP_MIN;
   assign minSystemMv = stepScale(`CCRB_MINSYS_BASE_MV, {1'b0, minSystemVoltage});
   // codes decode unclamped; top code 15 already gives 2.0 A
   assign sourceCurrentMa = 12'(stepScale(13'(`CCRB_SRC_I_BASE_MA), {1'b0, sourceCurrentLimit}));
   assign srcVClamped = (sourceVoltageLevel > `CCRB_SRC_V_MAX_CODE) ? `CCRB_SRC_V_MAX_CODE
                        : sourceVoltageLevel;
   assign sourceVoltageMv = stepScale(`CCRB_SRC_V_BASE_MV, {1'b0, srcVClamped});
   assign optimizedInputMa = 12'(stepScale(13'(`CCRB_OPT_BASE_MA), optimizedInputLimit));

endmodule // ccrb_register_bank

//--- ccrb_regs.svh
`ifndef CCRB_REGS_SVH
`define CCRB_REGS_SVH
// Contract
// - low-frequency pulse disable resets to 0; register reset restores it, watchdog does not.
// - host writes 1 to kick; device restarts watchdog and clears kick bit itself.
// - top-off duration: 00 off (reset), 01 15 min, 10 30 min, 11 45 min.
// - min system voltage 6.0 V plus 100 mV per count, reset 7.0 V, watchdog-proof.
// - temperature profile register at 08h resets to 0Dh; register reset and watchdog restore it.
// - hot threshold: 00 34.75 default, 01 37.75, 10 31.25 percent, 11 protection off.
// - cold threshold: 0 selects 77 percent (default), 1 selects 80 percent.
// - warm voltage: 00 suspend, 01 8.0 V default, 10 8.3 V, 11 target unchanged.
// - warm current: 0 limits to 40 percent, 1 (default) allows 100 percent.
// - cool current: 00 suspend, 01 20 percent default, 10 40, 11 100 percent.
// - source current limit 0.5 A plus 100 mA per count, up to 2.0 A, reset 2 A.
// - source voltage 4.5 V plus 100 mV per count, reset 5.1 V, clamp at 5.5 V.
// - source limit register at 09h resets to F6h; register reset and watchdog restore it.
// - optimized input limit read-only, 500 mA plus 100 mA per count, resets never touch it; rst here still loads zero.
// - register 0Ah low five bits have no fixed reset; upper three read zero.
// - reserved bits of 0Ah always read 0.
// - watchdog period: 00 disabled, 01 40 s default, 10 80 s, 11 160 s.

`define CCRB_ADDR_TIMER_SYS 8'h07
`define CCRB_ADDR_TEMP_PROFILE 8'h08
`define CCRB_ADDR_SOURCE_LIMITS 8'h09
`define CCRB_ADDR_OPT_INPUT 8'h0a

`define CCRB_BIT_LOWFREQ_DIS 7
`define CCRB_BIT_WD_KICK 6
`define CCRB_POS_TOPOFF 4
`define CCRB_POS_MINSYS 0
`define CCRB_POS_HOT 6
`define CCRB_BIT_COLD 5
`define CCRB_POS_WARM_V 3
`define CCRB_BIT_WARM_I 2
`define CCRB_POS_COOL_I 0
`define CCRB_POS_SRC_I 4
`define CCRB_POS_SRC_V 0

`define CCRB_RST_LOWFREQ_DIS 1'h0
`define CCRB_RST_TOPOFF 2'h0
`define CCRB_RST_MINSYS 4'ha
`define CCRB_RST_TEMP_PROFILE 8'h0d
`define CCRB_RST_SOURCE_LIMITS 8'hf6
`define CCRB_SRC_V_MAX_CODE 4'ha
`define CCRB_WD_PERIOD_DEFAULT 2'h1

`define CCRB_TOPOFF_STEP_MIN 8'h0f
`define CCRB_SRC_I_BASE_MA 12'h1f4
`define CCRB_SRC_V_BASE_MV 13'h1194
`define CCRB_MINSYS_BASE_MV 13'h1770
`define CCRB_OPT_BASE_MA 12'h1f4
`define CCRB_STEP_100 12'h064

`define CCRB_CLK_HZ 36'd200000000
`define CCRB_WD_BASE_S 36'd40
`define CCRB_WD_BASE_CYCLES (`CCRB_WD_BASE_S * `CCRB_CLK_HZ)
`endif

//--- ccrb_pkg.sv
package ccrb_pkg;
   typedef enum logic [1:0] {
      CCRB_WD_OFF = 2'h0,
      CCRB_WD_40S = 2'h1,
      CCRB_WD_80S = 2'h2,
      CCRB_WD_160S = 2'h3
   } ccrb_wd_period_t;

   typedef struct packed {
      logic lowfreqPulseDisable;
      logic watchdogKick;
      logic [1:0] topoffDuration;
      logic [3:0] minSystemVoltage;
      logic [7:0] tempProfile;
      logic [7:0] sourceLimits;
      logic [4:0] optimizedInputLimit;
      logic [37:0] wdCount;
      ccrb_wd_period_t wdPeriodSeen;
      logic wdExpired;
      logic [7:0] rdData;
   } ccrb_state_t;
endpackage

//--- ccrb_host_model.sv
`timescale 1ns/1ps
module ccrb_host_model
(
   // clock
   input wire logic clk,
   // register port
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   input wire logic [7:0] regRdData
);
   initial
   begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      // released data no longer shows the byte
      regWrData = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk);
      #1;
      regRead = 1'b0;
      d = regRdData;
   endtask
endmodule // ccrb_host_model

//--- ccrb_register_bank_chk.sv
`timescale 1ns/1ps
module ccrb_register_bank_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // inputs
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regResetCmd,
   input wire logic [4:0] optimizedInputLimitIn,
   // outputs
   input wire logic [7:0] regRdData,
   input wire logic watchdogExpired,
   input wire logic watchdogKickSeen,
   input wire logic lowfreqPulseDisable,
   input wire logic [1:0] topoffDuration,
   input wire logic [3:0] minSystemVoltage,
   input wire logic [1:0] hotThresholdSel,
   input wire logic hotProtectEnable,
   input wire logic [3:0] sourceCurrentLimit,
   input wire logic [3:0] sourceVoltageLevel,
   input wire logic [4:0] optimizedInputLimit,
   input wire logic [11:0] sourceCurrentMa,
   input wire logic [12:0] sourceVoltageMv
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_kick_one_cycle: assert property (regWrite && !regResetCmd && !watchdogExpired && regAddr == 8'h07
      && regWrData[6] |=> watchdogKickSeen ##1 !watchdogKickSeen) else $error("kick bit not one cycle");
   chk_reserved_zero: assert property (regRead && regAddr == 8'h0a |=> regRdData[7:5] == 3'h0)
      else $error("reserved bits not zero");
   chk_opt_copy: assert property (!$past(rst) |-> optimizedInputLimit == $past(optimizedInputLimitIn))
      else $error("optimized limit not copied");
   chk_src_volt_clamp: assert property (sourceVoltageMv == ((sourceVoltageLevel > 4'ha) ? 13'd5500
      : 13'd4500 + 13'd100 * sourceVoltageLevel)) else $error("source voltage decode wrong");
   chk_src_cur_decode: assert property (sourceCurrentMa == 12'd500 + 12'd100 * sourceCurrentLimit)
      else $error("source current decode wrong");
   chk_hot_protect: assert property (hotProtectEnable == (hotThresholdSel != 2'h3)) else $error("hot off wrong");
   chk_regrst_src: assert property (regResetCmd |=> {sourceCurrentLimit, sourceVoltageLevel} == 8'hf6)
      else $error("source limits not restored");
   chk_regrst_sys: assert property (regResetCmd |=> !lowfreqPulseDisable && topoffDuration == 2'h0
      && minSystemVoltage == 4'ha) else $error("timer fields not restored");
   chk_wd_keep_sys: assert property (watchdogExpired && !regWrite && !regResetCmd |=> $stable(minSystemVoltage)
      && $stable(lowfreqPulseDisable)) else $error("watchdog touched kept fields");
   chk_wd_restore: assert property (watchdogExpired && !regResetCmd |-> ##[1:2] topoffDuration == 2'h0
      && sourceCurrentLimit == 4'hf) else $error("watchdog restore missing");
   chk_src_write: assert property (regWrite && !regResetCmd && !watchdogExpired && regAddr == 8'h09
      |=> {sourceCurrentLimit, sourceVoltageLevel} == $past(regWrData)) else $error("source write lost");
endmodule // ccrb_register_bank_chk

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failCount++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic regResetCmd = 1'b0;
   logic [1:0] watchdogPeriod = 2'h0;
   logic [4:0] optimizedInputLimitIn = 5'h1c;
   logic regWrite, regRead, watchdogExpired, watchdogKickSeen, hotProtectEnable;
   logic [7:0] regAddr, regWrData, regRdData, topoffMinutes;
   logic [12:0] sourceVoltageMv;
   logic [11:0] optimizedInputMa;
   logic coldThresholdSel, warmCurrentSel;
   logic [1:0] warmVoltageSel, coolCurrentSel;
   logic [12:0] minSystemMv;
   logic [11:0] sourceCurrentMa;
   int failCount = 0;
   int checks = 0;
   ccrb_register_bank #(.WD_BASE_CYCLES(38'd20)) ccrb_register_bank_inst (.clk(clk), .rst(rst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regResetCmd(regResetCmd), .watchdogPeriod(watchdogPeriod), .optimizedInputLimitIn(optimizedInputLimitIn),
      .watchdogExpired(watchdogExpired), .watchdogKickSeen(watchdogKickSeen), .lowfreqPulseDisable(),
      .topoffDuration(), .minSystemVoltage(), .hotThresholdSel(), .coldThresholdSel(coldThresholdSel),
      .warmVoltageSel(warmVoltageSel), .warmCurrentSel(warmCurrentSel), .coolCurrentSel(coolCurrentSel),
      .sourceCurrentLimit(), .sourceVoltageLevel(), .optimizedInputLimit(), .topoffMinutes(topoffMinutes),
      .minSystemMv(minSystemMv), .sourceCurrentMa(sourceCurrentMa), .sourceVoltageMv(sourceVoltageMv),
      .optimizedInputMa(optimizedInputMa), .hotProtectEnable(hotProtectEnable));
   ccrb_host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData));
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic tDefaults();
      rdChk(8'h07, 8'h0a);
      rdChk(8'h08, 8'h0d);
      rdChk(8'h09, 8'hf6);
      rdChk(8'h0a, 8'h1c);
      rdChk(8'h20, 8'h00);
      `CHK(sourceVoltageMv, 13'h13ec)
      `CHK(optimizedInputMa, 12'hce4)
      `CHK(minSystemMv, 13'h1b58)
      `CHK(sourceCurrentMa, 12'h7d0)
      `CHK(coldThresholdSel, 1'b0)
      `CHK(warmVoltageSel, 2'h1)
      `CHK(warmCurrentSel, 1'b1)
      `CHK(coolCurrentSel, 2'h1)
   endtask
   task automatic tWrites();
      host.wr(8'h07, 8'hff);
      `CHK(watchdogKickSeen, 1'b1)
      rdChk(8'h07, 8'hbf);
      for (int i = 0; i < 4; i++)
      begin
         host.wr(8'h07, 8'(i << 4));
         `CHK(topoffMinutes, 8'(15 * i))
      end
      host.wr(8'h0a, 8'hff);
      rdChk(8'h0a, 8'h1c);
      host.wr(8'h08, 8'hc7);
      `CHK(hotProtectEnable, 1'b0)
      `CHK(coldThresholdSel, 1'b0)
      `CHK(warmVoltageSel, 2'h0)
      `CHK(warmCurrentSel, 1'b1)
      `CHK(coolCurrentSel, 2'h3)
      host.wr(8'h08, 8'h38);
      `CHK(coldThresholdSel, 1'b1)
      `CHK(warmVoltageSel, 2'h3)
      `CHK(warmCurrentSel, 1'b0)
      host.wr(8'h09, 8'hff);
      `CHK(sourceVoltageMv, 13'h157c)
      rdChk(8'h09, 8'hff);
   endtask
   task automatic tRegReset();
      @(posedge clk);
      #1 regResetCmd = 1'b1;
      @(posedge clk);
      #1 regResetCmd = 1'b0;
      rdChk(8'h07, 8'h0a);
      rdChk(8'h08, 8'h0d);
      rdChk(8'h09, 8'hf6);
   endtask
   task automatic tWatchdog();
      int n;
      host.wr(8'h07, 8'hf5);
      host.wr(8'h08, 8'h00);
      host.wr(8'h09, 8'h00);
      watchdogPeriod = 2'h1;
      for (n = 0; n < 100 && watchdogExpired !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      // off again so no second expiry lands in the reads
      watchdogPeriod = 2'h0;
      `CHK(n >= 18 && n <= 22, 1'b1)
      repeat (2) @(posedge clk);
      rdChk(8'h07, 8'h85);
      rdChk(8'h08, 8'h0d);
      rdChk(8'h09, 8'hf6);
   endtask
   task automatic tallyAndFinish();
      if (failCount == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #100000;
      failCount++;
      tallyAndFinish();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      tDefaults();
      tWrites();
      tRegReset();
      tWatchdog();
      tallyAndFinish();
   end
endmodule // tb_top
bind ccrb_register_bank ccrb_register_bank_chk ccrb_register_bank_chk_inst (.*);
